// ---- hdl/dtc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module dtc_top
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Configuration per timer
	input wire logic [1:0] run_i,
	input wire logic [1:0] counter_sel_i,
	input wire logic [1:0] toggle_en_i,
	input wire logic [2:0] mode0_i,
	input wire logic [2:0] mode1_i,
	// Software count load, flag clear and split run
	input wire logic [1:0] load_i,
	input wire logic [15:0] load_val_i,
	input wire logic [1:0] flag_clr_i,
	input wire logic split_run_i,
	// Event pins (two-way)
	input wire logic timer0_event_pin_i,
	input wire logic timer1_event_pin_i,
	output logic timer0_event_pin_o,
	output logic timer1_event_pin_o,
	output logic [1:0] pin_oe_o,
	// Status
	output logic [15:0] count0_o,
	output logic [15:0] count1_o,
	output logic [1:0] ovf_flag_o,
	output logic split_flag_o,
	output logic baud_ovf_o,
	output logic [1:0] pwm_o
);
	typedef struct packed {
		logic [15:0] c0;
		logic [15:0] c1;
		logic [1:0] flg;
		logic sflg;
		logic [1:0] tgl;
		logic [1:0] pwm;
		logic baud;
		logic [7:0] bsh;
	} dtc_top_s;
	dtc_top_s st_ff, nxt_st;
	// Kept apart: clears on the raw reset, the struct on its released copy
	logic [1:0] rs_ff;
	logic rst_n;
	dtc_tick_if tk();
	// =====
	// Reset release
	// Two flops so every register leaves reset on the same edge
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs_ff <= 2'h0;
		end else begin
			rs_ff <= {rs_ff[0], 1'b1};
		end
	end
	assign rst_n = rs_ff[1];
	// =====
	// Machine-cycle tick
	// Both timers share one tick so their counts stay in step
	dtc_tick u_tick (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.pin_i({timer1_event_pin_i, timer0_event_pin_i}),
		.tk(tk)
	);
	// =====
	// Per-mode step
	// Advance one timer; returns next count and overflow
	function automatic logic [16:0] dtc_step(input logic [2:0] md, input logic [15:0] c);
		logic [15:0] n;
		logic ov;
		n = c;
		ov = 1'b0;
		case (md)
			DTC_MODE_13B: begin
				n[4:0] = c[4:0] + 5'h01; // RULE_06
				if (c[4:0] == DTC_PRE_MAX) begin
					n[15:8] = c[15:8] + 8'h01; // RULE_14
					ov = (c[15:8] == DTC_BYTE_MAX);
				end
			end
			DTC_MODE_16B: begin
				n = c + 16'h0001; // RULE_07
				ov = (c == DTC_WORD_MAX);
			end
			DTC_MODE_RLD, DTC_MODE_SPL: begin
				n[7:0] = (c[7:0] == DTC_BYTE_MAX) ? c[15:8] : c[7:0] + 8'h01; // RULE_08
				ov = (c[7:0] == DTC_BYTE_MAX);
			end
			DTC_MODE_PWM: begin
				n[7:0] = c[7:0] + 8'h01; // RULE_12
				ov = (c[7:0] == DTC_BYTE_MAX);
			end
			default: begin
				n = c;
			end
		endcase
		return {ov, n};
	endfunction
	// =====
	// Next state
	logic [16:0] s0, s1;
	logic inc0, inc1, ov0, ov1, ovh;
	always_comb begin
		nxt_st = st_ff;
		// Source: machine cycle or falling pin edge
		inc0 = run_i[0] & (counter_sel_i[0] ? tk.pin_fall[0] : tk.mc_tick); // RULE_02 RULE_03
		inc1 = run_i[1] & (counter_sel_i[1] ? tk.pin_fall[1] : tk.mc_tick);
		s0 = dtc_step(mode0_i, st_ff.c0);
		// Mode 3 timer 0 low byte counts plain 8-bit, no reload
		if (mode0_i == DTC_MODE_SPL) begin
			s0 = {st_ff.c0[7:0] == DTC_BYTE_MAX, st_ff.c0[15:8], st_ff.c0[7:0] + 8'h01}; // RULE_10
		end
		s1 = dtc_step(mode1_i == DTC_MODE_SPL ? DTC_MODE_RLD : mode1_i, st_ff.c1);
		ov0 = inc0 & s0[16];
		// Timer 1 counts its shadow only for the baud tick in mode 3
		ov1 = inc1 & s1[16] & (mode1_i != DTC_MODE_SPL);
		ovh = (mode0_i == DTC_MODE_SPL) & split_run_i & tk.mc_tick
			& (st_ff.c0[15:8] == DTC_BYTE_MAX);
		if (inc0) begin
			nxt_st.c0 = s0[15:0];
		end
		if ((mode0_i == DTC_MODE_SPL) && split_run_i && tk.mc_tick) begin
			nxt_st.c0[15:8] = st_ff.c0[15:8] + 8'h01; // RULE_10
		end
		if (inc1 && mode1_i != DTC_MODE_SPL) begin
			nxt_st.c1 = s1[15:0]; // RULE_09
		end
		// Mode 3 baud source is the shadow while the visible count holds
		nxt_st.baud = inc1 & ((mode1_i == DTC_MODE_SPL) ? (st_ff.bsh == DTC_BYTE_MAX)
			: s1[16]); // RULE_11
		if (load_i[0]) begin
			nxt_st.c0 = load_val_i;
		end
		if (load_i[1]) begin
			nxt_st.c1 = load_val_i;
		end
		// Shadow reloads from the held high byte, as in mode 2
		if (mode1_i == DTC_MODE_SPL) begin
			if (inc1) begin
				nxt_st.bsh = (st_ff.bsh == DTC_BYTE_MAX) ? st_ff.c1[15:8]
					: st_ff.bsh + 8'h01; // RULE_11
			end
			if (load_i[1]) begin
				nxt_st.bsh = load_val_i[7:0];
			end
		end else begin
			// Tracks the count so mode 3 starts where the count stands
			nxt_st.bsh = nxt_st.c1[7:0];
		end
		// Set wins over software clear
		nxt_st.flg = (st_ff.flg & ~flag_clr_i) | {ov1, ov0}; // RULE_13
		nxt_st.sflg = (st_ff.sflg & ~flag_clr_i[1]) | ovh;
		nxt_st.tgl = st_ff.tgl ^ ({ov1, ov0} & toggle_en_i); // RULE_05
		nxt_st.pwm[0] = (mode0_i == DTC_MODE_PWM) & (st_ff.c0[7:0] < st_ff.c0[15:8]); // RULE_12
		nxt_st.pwm[1] = (mode1_i == DTC_MODE_PWM) & (st_ff.c1[7:0] < st_ff.c1[15:8]);
	end
	// =====
	// Registers
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{tgl: 2'h3, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	// =====
	// Outputs
	assign timer0_event_pin_o = st_ff.tgl[0];
	assign timer1_event_pin_o = st_ff.tgl[1];
	assign pin_oe_o = toggle_en_i & ~counter_sel_i;
	assign count0_o = st_ff.c0;
	assign count1_o = st_ff.c1;
	assign ovf_flag_o = st_ff.flg;
	assign split_flag_o = st_ff.sflg;
	assign baud_ovf_o = st_ff.baud;
	assign pwm_o = st_ff.pwm;
	// =====
	// Assertions
	sequence ovf16_s;
		run_i[0] && !counter_sel_i[0] && tk.mc_tick && mode0_i == DTC_MODE_16B
			&& count0_o == DTC_WORD_MAX && !load_i[0];
	endsequence
	wrap16_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		ovf16_s |=> count0_o == 16'h0000 && ovf_flag_o[0]) else $error("16-bit wrap wrong"); // RULE_07
	hold_t1_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode1_i == DTC_MODE_SPL && !load_i[1] |=> $stable(count1_o)) else $error("timer1 moved"); // RULE_09
	reload_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		run_i[1] && !counter_sel_i[1] && tk.mc_tick && mode1_i == DTC_MODE_RLD
		&& count1_o[7:0] == DTC_BYTE_MAX && !load_i[1]
		|=> count1_o[7:0] == $past(count1_o[15:8])) else $error("no reload"); // RULE_08
	timer_inc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		run_i[1] && !counter_sel_i[1] && tk.mc_tick && mode1_i == DTC_MODE_16B && !load_i[1]
		|=> count1_o == $past(count1_o) + 16'h0001) else $error("no increment"); // RULE_02
	pre_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		run_i[1] && !counter_sel_i[1] && tk.mc_tick && mode1_i == DTC_MODE_13B && !load_i[1]
		&& count1_o[4:0] == DTC_PRE_MAX
		|=> count1_o[15:8] == $past(count1_o[15:8]) + 8'h01) else $error("prescale wrap"); // RULE_14
	flag_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		ovf_flag_o[0] && !flag_clr_i[0] |=> ovf_flag_o[0]) else $error("flag lost"); // RULE_13
	toggle_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(ovf16_s and toggle_en_i[0]) |=> timer0_event_pin_o != $past(timer0_event_pin_o))
		else $error("no toggle"); // RULE_05
	split_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		mode0_i == DTC_MODE_SPL && split_run_i && tk.mc_tick && !load_i[0]
		|=> count0_o[15:8] == $past(count0_o[15:8]) + 8'h01) else $error("split high idle"); // RULE_10
	// Baud pulse comes from the hidden shadow, not the held count
	sequence t1_split_tick_s;
		run_i[1] && !counter_sel_i[1] && tk.mc_tick && mode1_i == DTC_MODE_SPL && !load_i[1];
	endsequence
	baud_split_a: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE_11
		t1_split_tick_s ##0 st_ff.bsh == DTC_BYTE_MAX |=> baud_ovf_o) else $error("no baud tick");
	split_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE_10
		mode0_i == DTC_MODE_SPL && split_run_i && tk.mc_tick && count0_o[15:8] == DTC_BYTE_MAX
		|=> split_flag_o) else $error("split flag not set");
	pwm_level_a: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE_12
		mode1_i == DTC_MODE_PWM && count1_o[7:0] < count1_o[15:8] |=> pwm_o[1])
		else $error("pwm low");
	flag_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE_13
		flag_clr_i[0] && !ov0 |=> !ovf_flag_o[0]) else $error("flag not cleared");
endmodule : dtc_top
`default_nettype wire

// ---- hdl/dtc_pkg.sv ----
// What this block does
// [RULE_01] A machine cycle is two clock cycles; peripheral tick is clock divided by two.
// [RULE_02] Timer function: count increments once per machine cycle while running.
// [RULE_03] Counter function: count increments on each falling edge of the event pin.
// [RULE_04] Event pin sampled once per machine cycle; source holds levels one machine cycle.
// [RULE_05] Optional per-timer toggle of its pin on every overflow; code drives the pin only while counter_sel_i is low (timer function).
// [RULE_06] Mode 0: 13-bit count, 8-bit counter behind divide-by-32 prescaler.
// [RULE_07] Mode 1: as mode 0 but all 16 bits count.
// [RULE_08] Mode 2: 8-bit counter reloading from held high byte on overflow.
// [RULE_09] Timer 1 in mode 3 stops and holds its value.
// [RULE_10] Timer 0 in mode 3 splits into two independent 8-bit counters.
// [RULE_11] Timer 1 in mode 3 still gives overflow pulses for the serial port.
// [RULE_12] Mode 6: PWM output with full period of 256 timer clocks.
// [RULE_13] Each overflow sets a sticky flag that software reads and clears.
// [RULE_14] Mode 0: low five bits prescale; high byte increments when prescaler wraps.
package dtc_pkg;
	localparam logic [2:0] DTC_MODE_13B = 3'h0;
	localparam logic [2:0] DTC_MODE_16B = 3'h1;
	localparam logic [2:0] DTC_MODE_RLD = 3'h2;
	localparam logic [2:0] DTC_MODE_SPL = 3'h3;
	localparam logic [2:0] DTC_MODE_PWM = 3'h6;
	localparam logic [4:0] DTC_PRE_MAX = 5'h1F;
	localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;
	localparam logic [15:0] DTC_WORD_MAX = 16'hFFFF;
	localparam int DTC_CYC_PER_MC = 2;
endpackage : dtc_pkg

// ---- hdl/dtc_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Shared machine-cycle tick and sampled event pins
interface dtc_tick_if;
	logic mc_tick;
	logic [1:0] pin_fall;
	modport src (output mc_tick, output pin_fall);
	modport dst (input mc_tick, input pin_fall);
endinterface : dtc_tick_if
`default_nettype wire

// ---- hdl/dtc_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
module dtc_tick
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Raw event pins
	input wire logic [1:0] pin_i,
	// Tick out
	dtc_tick_if.src tk
);
	typedef struct packed {
		logic phase;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] smp;
	} dtc_tick_s;
	dtc_tick_s st_ff, nxt_st;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.phase = ~st_ff.phase; // RULE_01
		nxt_st.s1 = pin_i;
		nxt_st.s2 = st_ff.s1;
		if (st_ff.phase) begin
			nxt_st.smp = st_ff.s2; // RULE_04
		end
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '{phase: 1'b0, s1: 2'h3, s2: 2'h3, smp: 2'h3};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign tk.mc_tick = st_ff.phase;
	// Falling edge between two machine-cycle samples
	assign tk.pin_fall = st_ff.phase ? (st_ff.smp & ~st_ff.s2) : 2'h0; // RULE_03
	tick_period_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tk.mc_tick |=> !tk.mc_tick ##1 tk.mc_tick) else $error("tick not every two clocks"); // RULE_01
	fall_on_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		|tk.pin_fall |-> tk.mc_tick) else $error("edge outside tick"); // RULE_04
endmodule : dtc_tick
`default_nettype wire

// ---- verification/dtc_pin_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====
// Event source on both pins; idle high, like a pulled-up pin
module dtc_pin_src (
	input wire logic clock_i,
	output logic [1:0] lvl_o
);
	initial lvl_o = 2'h3;
	// Each level held for hold clocks, at least one machine cycle
	task automatic pulses(input int p, input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge clock_i);
			#1 lvl_o[p] = 1'b0;
			repeat (hold) @(posedge clock_i);
			#1 lvl_o[p] = 1'b1;
		end
	endtask
endmodule // dtc_pin_src
`default_nettype wire

// ---- verification/dual_timer_counter_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_tb;
	import dtc_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] run_i = '0, sel_i = '0, tog_i = '0, load_i = '0, clr_i = '0;
	logic [2:0] mode0_i = '0, mode1_i = '0;
	logic [15:0] load_val_i = '0;
	logic split_i = 1'b0;
	logic p0_o, p1_o, split_flag_o, baud_o;
	logic [1:0] oe_o, flag_o, pwm_o, lvl;
	logic [15:0] count0_o, count1_o, v;
	int num_errors = 0;
	int checked = 0;
	int k;
	// Pin level: design wins while it drives
	wire pin0 = oe_o[0] ? p0_o : lvl[0];
	wire pin1 = oe_o[1] ? p1_o : lvl[1];
	always #25 clock_i = ~clock_i;
	dtc_pin_src i_src (.clock_i(clock_i), .lvl_o(lvl));
	dtc_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run_i), .counter_sel_i(sel_i),
		.toggle_en_i(tog_i), .mode0_i(mode0_i), .mode1_i(mode1_i), .load_i(load_i),
		.load_val_i(load_val_i), .flag_clr_i(clr_i), .split_run_i(split_i),
		.timer0_event_pin_i(pin0), .timer1_event_pin_i(pin1), .timer0_event_pin_o(p0_o),
		.timer1_event_pin_o(p1_o), .pin_oe_o(oe_o), .count0_o(count0_o), .count1_o(count1_o),
		.ovf_flag_o(flag_o), .split_flag_o(split_flag_o), .baud_ovf_o(baud_o), .pwm_o(pwm_o));
	// =====
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic ld(input int t, input logic [15:0] d);
		load_val_i = d;
		load_i[t] = 1'b1;
		cyc(1);
		load_i = '0;
	endtask
	// Bounded wait for the next count change
	task automatic wchg(input int t);
		v = t ? count1_o : count0_o;
		for (k = 0; k < 600 && (t ? count1_o : count0_o) === v; k++) cyc(1);
		if (k == 600) begin
			num_errors++;
			complete_run();
		end
	endtask
	// =====
	// Scenarios
	task automatic s_rate();
		mode0_i = DTC_MODE_16B;
		ld(0, 16'h0100);
		run_i[0] = 1'b1;
		wchg(0);
		v = count0_o;
		cyc(20);
		chk("rate", v + 16'h000A, count0_o);
	endtask
	task automatic s_wrap();
		tog_i[0] = 1'b1;
		ld(0, DTC_WORD_MAX);
		wchg(0);
		chk("wrap", 16'h0000, count0_o);
		chk("flag", 16'h0001, {15'h0, flag_o[0]});
		chk("toggle", 16'h0000, {15'h0, pin0});
		clr_i[0] = 1'b1;
		cyc(1);
		clr_i = '0;
		cyc(1);
		chk("clear", 16'h0000, {15'h0, flag_o[0]});
		tog_i = '0;
	endtask
	task automatic s_modes();
		mode0_i = DTC_MODE_13B;
		ld(0, 16'h001F);
		wchg(0);
		chk("mode0", 16'h0100, count0_o);
		mode0_i = DTC_MODE_RLD;
		ld(0, 16'h40FF);
		wchg(0);
		chk("reload", 16'h4040, count0_o);
	endtask
	task automatic s_t1();
		mode1_i = DTC_MODE_13B;
		tog_i[1] = 1'b1;
		ld(1, 16'h001F);
		run_i[1] = 1'b1;
		wchg(1);
		chk("t1 mode0", 16'h0100, count1_o);
		mode1_i = DTC_MODE_RLD;
		ld(1, 16'h40FF);
		wchg(1);
		chk("t1 reload", 16'h4040, count1_o);
		chk("t1 flag", 16'h0001, {15'h0, flag_o[1]});
		chk("t1 toggle", 16'h0000, {15'h0, pin1});
		mode1_i = DTC_MODE_16B;
		ld(1, 16'h0200);
		wchg(1);
		v = count1_o;
		cyc(20);
		chk("t1 rate", v + 16'h000A, count1_o);
		run_i[1] = 1'b0;
		tog_i[1] = 1'b0;
	endtask
	task automatic s_split();
		mode1_i = DTC_MODE_SPL;
		ld(1, 16'h1234);
		run_i[1] = 1'b1;
		cyc(40);
		chk("stop", 16'h1234, count1_o);
		for (k = 0; k < 1200 && baud_o !== 1'b1; k++) cyc(1);
		chk("baud", 16'h0001, {15'h0, baud_o});
		run_i = '0;
		mode0_i = DTC_MODE_SPL;
		ld(0, 16'hFE05);
		split_i = 1'b1;
		wchg(0);
		v = count0_o;
		cyc(20);
		chk("split", v + 16'h0A00, count0_o);
		chk("split flag", 16'h0001, {15'h0, split_flag_o});
		split_i = 1'b0;
	endtask
	task automatic s_count();
		mode0_i = DTC_MODE_16B;
		sel_i[0] = 1'b1;
		ld(0, 16'h0000);
		run_i[0] = 1'b1;
		i_src.pulses(0, 5, 3);
		cyc(8);
		chk("events", 16'h0005, count0_o);
		run_i = '0;
	endtask
	task automatic s_pwm();
		mode1_i = DTC_MODE_PWM;
		ld(1, 16'h4000);
		run_i[1] = 1'b1;
		cyc(8);
		v = '0;
		repeat (512) begin
			v = v + {15'h0, pwm_o[1]};
			cyc(1);
		end
		chk("pwm", 16'h0080, v);
	endtask
	initial begin
		cyc(8);
		rst_n_i = 1'b1;
		cyc(4);
		s_rate();
		s_wrap();
		s_modes();
		s_t1();
		s_split();
		s_count();
		s_pwm();
		complete_run();
	end
endmodule // dual_timer_counter_tb
`default_nettype wire
